// >>> design/khm_defines.svh
// Offsets, field positions, reset values and timing counts of the host mailbox
`ifndef KHM_DEFINES_SVH
`define KHM_DEFINES_SVH
`define KHM_DATA_PORT 8'h60
`define KHM_CMD_PORT 8'h64
`define KHM_ST_OUT_FULL 0
`define KHM_ST_IN_FULL 1
`define KHM_ST_CD 3
`define KHM_ST_RST 8'h00
`define KHM_ST_USER_MASK 8'hf4
`define KHM_P2_RST 8'hcc
`define KHM_P2_A20 1
`define KHM_P2_MOUSE_DAT 2
`define KHM_P2_MOUSE_CLK 3
`define KHM_P2_KBD_IRQ 4
`define KHM_P2_AUX_IRQ 5
`define KHM_P2_KBD_CLK 6
`define KHM_P2_KBD_DAT 7
`define KHM_PIN_KBD_CLK 0
`define KHM_PIN_KBD_DAT 1
`define KHM_PIN_MOUSE_CLK 2
`define KHM_PIN_MOUSE_DAT 3
`define KHM_CLK_NS 10
`define KHM_DRIVE_NS 500
`define KHM_DRIVE_CYC (`KHM_DRIVE_NS / `KHM_CLK_NS)
`endif

// >>> design/khm_drv_if.sv
// Port-pin driver link between mailbox core and pin driver
`timescale 1ns/1ps
`default_nettype none
interface khm_drv_if;
    logic level;
    logic open_drain;
    logic pin_o;
    logic pin_oe_n;
    modport ctrl (output level, output open_drain, input pin_o, input pin_oe_n);
    modport drv (input level, input open_drain, output pin_o, output pin_oe_n);
endinterface
`default_nettype wire

// >>> design/khm_mailbox.sv
// Host mailbox core: buffers, status, host irqs, port pins and power state
`timescale 1ns/1ps
`default_nettype none
`include "khm_defines.svh"
module khm_mailbox import khm_pkg::*; #(
    parameter int DRIVE_CYC = `KHM_DRIVE_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Host I/O cycles, already decoded from the bus
    input wire logic [7:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    // Microcontroller buffer access
    input wire logic uc_out_wr,
    input wire logic [7:0] uc_out_data,
    input wire logic uc_in_rd,
    output logic [7:0] uc_in_data,
    input wire logic uc_status_wr,
    input wire logic [7:0] uc_status_user,
    output logic [7:0] uc_status,
    // Microcontroller port two
    input wire logic uc_port2_wr,
    input wire logic [7:0] uc_port2_data,
    output logic [7:0] uc_port2,
    // Microcontroller instructions and interrupt control
    input wire logic uc_en_flags,
    input wire logic uc_halt,
    input wire logic uc_stop,
    input wire logic uc_in_full_irq_en,
    input wire logic timer_ovf,
    input wire logic uc_timer_ack,
    output logic uc_in_full_irq,
    output logic uc_timer_irq,
    // Power control
    output logic alu_clk_en,
    output logic timer_clk_en,
    output logic osc_en,
    output logic wake_call_irq,
    output logic wake_next_instr,
    // Host interrupts
    output logic kbd_irq_out,
    output logic aux_irq_out,
    // Gate A20 pin
    input wire logic cfg_open_drain,
    output logic gate_a20_o,
    output logic gate_a20_oe_n,
    // Keyboard and mouse open-drain pins
    input wire logic [3:0] kbd_mouse_pin_i,
    output logic [3:0] kbd_mouse_pin_o,
    output logic [3:0] kbd_mouse_pin_oe_n,
    output logic [3:0] pin_readback
);
    localparam khm_byte_t ST_USER = `KHM_ST_USER_MASK;

    khm_byte_t in_buf_q;
    khm_byte_t out_buf_q;
    khm_byte_t user_q;
    khm_byte_t port2_q;
    logic out_full_q;
    logic out_full_d;
    logic in_full_q;
    logic in_full_d;
    logic cd_q;
    logic flags_en_q;
    logic timer_irq_q;
    khm_pwr_e pwr_q;
    logic host_hit;
    logic host_in_wr;
    logic host_data_rd;

    // Only the two documented ports answer; other addresses are ignored
    assign host_hit = (host_addr == `KHM_DATA_PORT) || (host_addr == `KHM_CMD_PORT);
    assign host_in_wr = host_wr && host_hit;
    assign host_data_rd = host_rd && (host_addr == `KHM_DATA_PORT);

    // Input buffer and command/data bit taken on each host write
    always_ff @(posedge clock) begin
        if (srst) begin
            in_buf_q <= 8'h00;
            cd_q <= 1'b0;
        end else if (host_in_wr) begin
            in_buf_q <= host_wdata;
            cd_q <= host_addr[2];
        end
    end

    // Input-full: a host write in the clearing cycle wins
    always_comb begin
        in_full_d = in_full_q;
        if (uc_in_rd) begin
            in_full_d = 1'b0;
        end
        if (host_in_wr) begin
            in_full_d = 1'b1;
        end
    end

    // Output-full: a controller write in the clearing cycle wins
    always_comb begin
        out_full_d = out_full_q;
        if (host_data_rd) begin
            out_full_d = 1'b0;
        end
        if (uc_out_wr) begin
            out_full_d = 1'b1;
        end
    end

    // Flag state and output buffer
    always_ff @(posedge clock) begin
        if (srst) begin
            in_full_q <= 1'b0;
            out_full_q <= 1'b0;
            out_buf_q <= 8'h00;
        end else begin
            in_full_q <= in_full_d;
            out_full_q <= out_full_d;
            if (uc_out_wr) begin
                out_buf_q <= uc_out_data;
            end
        end
    end

    // User bits of status, writable only by the controller
    always_ff @(posedge clock) begin
        if (srst) begin
            user_q <= `KHM_ST_RST;
        end else if (uc_status_wr) begin
            user_q <= uc_status_user & ST_USER;
        end
    end

    // Host read data, returned one cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            host_rdata <= 8'h00;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_rd && host_hit;
            if (host_rd && host_addr == `KHM_CMD_PORT) begin
                host_rdata <= {user_q[7:4], cd_q, user_q[2], in_full_q, out_full_q};
            end else if (host_data_rd) begin
                host_rdata <= out_buf_q;
            end
        end
    end

    // Controller view of buffers and status; status is one cycle behind the flags, input data is not
    always_ff @(posedge clock) begin
        if (srst) begin
            uc_in_data <= 8'h00;
            uc_status <= `KHM_ST_RST;
        end else begin
            uc_in_data <= host_in_wr ? host_wdata : in_buf_q;
            uc_status <= {user_q[7:4], cd_q, user_q[2], in_full_q, out_full_q};
        end
    end

    // Port two latch; reset value keeps both irqs low and all pins low
    always_ff @(posedge clock) begin
        if (srst) begin
            port2_q <= `KHM_P2_RST;
            uc_port2 <= `KHM_P2_RST;
        end else begin
            if (uc_port2_wr) begin
                port2_q <= uc_port2_data;
            end
            uc_port2 <= port2_q;
        end
    end

    // Flag enabling latches until reset; no instruction turns it off
    always_ff @(posedge clock) begin
        if (srst) begin
            flags_en_q <= 1'b0;
        end else if (uc_en_flags) begin
            flags_en_q <= 1'b1;
        end
    end

    // Host interrupts, registered so the pins never glitch
    always_ff @(posedge clock) begin
        if (srst) begin
            kbd_irq_out <= 1'b0;
            aux_irq_out <= 1'b0;
        end else if (flags_en_q) begin
            kbd_irq_out <= port2_q[`KHM_P2_KBD_IRQ] & out_full_q;
            aux_irq_out <= port2_q[`KHM_P2_AUX_IRQ] & ~in_full_q;
        end else begin
            kbd_irq_out <= port2_q[`KHM_P2_KBD_IRQ];
            aux_irq_out <= port2_q[`KHM_P2_AUX_IRQ];
        end
    end

    // Controller interrupt sources; a new overflow beats the acknowledge
    always_ff @(posedge clock) begin
        if (srst) begin
            timer_irq_q <= 1'b0;
            uc_in_full_irq <= 1'b0;
            uc_timer_irq <= 1'b0;
        end else begin
            if (timer_ovf) begin
                timer_irq_q <= 1'b1;
            end else if (uc_timer_ack) begin
                timer_irq_q <= 1'b0;
            end
            uc_in_full_irq <= in_full_q & uc_in_full_irq_en;
            uc_timer_irq <= timer_irq_q;
        end
    end

    // Power state; reset itself is the other exit and restarts at zero
    always_ff @(posedge clock) begin
        if (srst) begin
            pwr_q <= KHM_PWR_RUN;
        end else begin
            unique case (pwr_q)
                KHM_PWR_RUN: begin
                    if (uc_stop) begin
                        pwr_q <= KHM_PWR_STOP;
                    end else if (uc_halt) begin
                        pwr_q <= KHM_PWR_HALT;
                    end
                end
                KHM_PWR_HALT: begin
                    if (host_in_wr) begin
                        pwr_q <= KHM_PWR_RUN;
                    end
                end
                KHM_PWR_STOP: begin
                    if (host_in_wr) begin
                        pwr_q <= KHM_PWR_RUN;
                    end
                end
                default: begin
                    pwr_q <= KHM_PWR_RUN;
                end
            endcase
        end
    end

    // Clock gates and wake pulses; a host write wake chooses irq or next
    always_ff @(posedge clock) begin
        if (srst) begin
            alu_clk_en <= 1'b1;
            timer_clk_en <= 1'b1;
            osc_en <= 1'b1;
            wake_call_irq <= 1'b0;
            wake_next_instr <= 1'b0;
        end else begin
            alu_clk_en <= (pwr_q == KHM_PWR_RUN);
            timer_clk_en <= (pwr_q != KHM_PWR_STOP);
            osc_en <= (pwr_q != KHM_PWR_STOP);
            wake_call_irq <= (pwr_q != KHM_PWR_RUN) && host_in_wr && uc_in_full_irq_en;
            wake_next_instr <= (pwr_q != KHM_PWR_RUN) && host_in_wr && !uc_in_full_irq_en;
        end
    end

    // Gate A20: port bit out through the shared pin driver
    khm_drv_if a20_if ();
    assign a20_if.level = port2_q[`KHM_P2_A20];
    // Open-drain is chosen by cfg_open_drain; no input or invert path exists
    assign a20_if.open_drain = cfg_open_drain;
    assign gate_a20_o = a20_if.pin_o;
    assign gate_a20_oe_n = a20_if.pin_oe_n;
    khm_port_driver #(.HIGH_CYC(DRIVE_CYC)) u_a20_drv (
        .clock(clock),
        .srst(srst),
        .pin(a20_if.drv)
    );

    // Keyboard/mouse pins only ever pull low: inverted port bits enable drive
    always_ff @(posedge clock) begin
        if (srst) begin
            kbd_mouse_pin_o <= 4'h0;
            kbd_mouse_pin_oe_n <= 4'h0;
        end else begin
            kbd_mouse_pin_o <= 4'h0;
            kbd_mouse_pin_oe_n[`KHM_PIN_KBD_CLK] <= ~port2_q[`KHM_P2_KBD_CLK];
            kbd_mouse_pin_oe_n[`KHM_PIN_KBD_DAT] <= ~port2_q[`KHM_P2_KBD_DAT];
            kbd_mouse_pin_oe_n[`KHM_PIN_MOUSE_CLK] <= ~port2_q[`KHM_P2_MOUSE_CLK];
            kbd_mouse_pin_oe_n[`KHM_PIN_MOUSE_DAT] <= ~port2_q[`KHM_P2_MOUSE_DAT];
        end
    end

    // Pin levels read back through the synchroniser
    khm_sync #(.WIDTH(4)) u_pin_sync (
        .clock(clock),
        .srst(srst),
        .async_in(kbd_mouse_pin_i),
        .sync_out(pin_readback)
    );

    // Host cycle shapes used below
    sequence cmd_wr_s;
        host_wr && host_addr == `KHM_CMD_PORT;
    endsequence
    sequence data_wr_s;
        host_wr && host_addr == `KHM_DATA_PORT;
    endsequence
    sequence halted_wr_s;
        pwr_q == KHM_PWR_HALT ##0 host_in_wr;
    endsequence

    cmd_write_a: assert property (@(posedge clock) disable iff (srst)
        cmd_wr_s |=> cd_q && in_full_q ##1 uc_status[3] && uc_status[1])
        else $error("command write did not mark command and input-full");
    data_write_a: assert property (@(posedge clock) disable iff (srst)
        data_wr_s |=> !cd_q && in_full_q)
        else $error("data write did not clear command bit and set input-full");
    cd_source_a: assert property (@(posedge clock) disable iff (srst)
        host_in_wr |-> ##1 (cd_q == $past(host_addr[2])) ##1 (uc_status[3] == $past(cd_q)))
        else $error("command/data bit not taken from address bit 2");
    out_full_set_a: assert property (@(posedge clock) disable iff (srst)
        uc_out_wr |=> out_full_q ##1 uc_status[0])
        else $error("controller write did not set output-full");
    out_full_clr_a: assert property (@(posedge clock) disable iff (srst)
        host_data_rd && !uc_out_wr |=> !out_full_q)
        else $error("host data read did not clear output-full");
    in_full_clr_a: assert property (@(posedge clock) disable iff (srst)
        uc_in_rd && !host_in_wr |=> !in_full_q ##1 !uc_in_full_irq)
        else $error("controller read did not clear input-full and its irq");
    kbd_gated_a: assert property (@(posedge clock) disable iff (srst)
        flags_en_q |-> ##1 (kbd_irq_out == $past(port2_q[4] & out_full_q)))
        else $error("keyboard irq not gated by output-full");
    kbd_direct_a: assert property (@(posedge clock) disable iff (srst)
        !flags_en_q |-> ##1 (kbd_irq_out == $past(port2_q[4])))
        else $error("keyboard irq not following port bit four");
    aux_irq_a: assert property (@(posedge clock) disable iff (srst)
        flags_en_q |-> ##1 (aux_irq_out == $past(port2_q[5] & ~in_full_q)))
        else $error("aux irq not inverted input-full");
    aux_direct_a: assert property (@(posedge clock) disable iff (srst)
        !flags_en_q |-> ##1 (aux_irq_out == $past(port2_q[5])))
        else $error("aux irq not following port bit five");
    flags_sticky_a: assert property (@(posedge clock) disable iff (srst)
        flags_en_q |=> flags_en_q [*4])
        else $error("flag enabling dropped before reset");
    reset_state_a: assert property (@(posedge clock)
        srst |=> uc_status == 8'h00 && !kbd_irq_out && kbd_mouse_pin_oe_n == 4'h0)
        else $error("reset defaults wrong");
    halt_clock_a: assert property (@(posedge clock) disable iff (srst)
        pwr_q == KHM_PWR_RUN && uc_halt && !uc_stop |=> ##1 !alu_clk_en && timer_clk_en)
        else $error("halt did not stop only the ALU clock");
    halt_wake_a: assert property (@(posedge clock) disable iff (srst)
        halted_wr_s |=> (wake_call_irq == $past(uc_in_full_irq_en)) && pwr_q == KHM_PWR_RUN)
        else $error("host write wake chose wrong resume path");
    stop_osc_a: assert property (@(posedge clock) disable iff (srst)
        pwr_q == KHM_PWR_STOP && !host_in_wr |=> !osc_en)
        else $error("oscillator running in stop mode");
    timer_irq_a: assert property (@(posedge clock) disable iff (srst)
        timer_ovf |=> ##1 uc_timer_irq)
        else $error("timer overflow irq lost");
endmodule
`default_nettype wire

// >>> design/khm_pkg.sv
// Types shared by the host mailbox modules
package khm_pkg;
    // Controller power state, Gray along run, halt, stop
    typedef enum logic [1:0] {
        KHM_PWR_RUN = 2'b00,
        KHM_PWR_HALT = 2'b01,
        KHM_PWR_STOP = 2'b11
    } khm_pwr_e;
    typedef logic [7:0] khm_byte_t;
endpackage

// >>> design/khm_port_driver.sv
// Port pin driver with brief active-high drive or open-drain mode
`timescale 1ns/1ps
`default_nettype none
`include "khm_defines.svh"
module khm_port_driver import khm_pkg::*; #(
    parameter int HIGH_CYC = `KHM_DRIVE_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Pin control
    khm_drv_if.drv pin
);
    localparam logic [7:0] HC8 = 8'(HIGH_CYC);
    localparam int HC = HIGH_CYC;
    logic prev_q;
    logic [7:0] cnt_q;

    // Drive high only long enough to beat the pull-up's slow edge
    always_ff @(posedge clock) begin
        if (srst) begin
            prev_q <= 1'b0;
            cnt_q <= 8'h00;
            pin.pin_o <= 1'b0;
            pin.pin_oe_n <= 1'b0;
        end else begin
            prev_q <= pin.level;
            if (!pin.level) begin
                pin.pin_o <= 1'b0;
                pin.pin_oe_n <= 1'b0;
                cnt_q <= 8'h00;
            end else if (pin.open_drain) begin
                pin.pin_oe_n <= 1'b1;
                cnt_q <= 8'h00;
            end else if (!prev_q) begin
                pin.pin_o <= 1'b1;
                pin.pin_oe_n <= 1'b0;
                cnt_q <= HC8;
            end else if (cnt_q > 8'h01) begin
                cnt_q <= cnt_q - 8'h01;
            end else begin
                pin.pin_oe_n <= 1'b1;
                cnt_q <= 8'h00;
            end
        end
    end

    drive_release_a: assert property (@(posedge clock) disable iff (srst)
        ($rose(pin.pin_o) && pin.level && !pin.open_drain) |-> ##[HC:HC] pin.pin_oe_n)
        else $error("active high drive not released on time");
    od_no_high_a: assert property (@(posedge clock) disable iff (srst)
        $past(pin.open_drain) && $past(pin.level) && pin.open_drain |-> pin.pin_oe_n)
        else $error("open-drain pin driven while port bit is one");
endmodule
`default_nettype wire

// >>> design/khm_sync.sv
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
`default_nettype none
module khm_sync import khm_pkg::*; #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Pin levels in, settled levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // Shift chain; the first stage feeds only the second
    always_ff @(posedge clock) begin
        if (srst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Per bit, take the level once two stages agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock) begin
            if (srst) begin
                sync_out[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                sync_out[i] <= s3_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/keyboard_host_mailbox_test.sv
// Self-checking bench for the host mailbox core
`timescale 1ns/1ps
`default_nettype none
module keyboard_host_mailbox_test;
    import khm_pkg::*;
    localparam int DRV = 4;
    logic clock = '0, srst = '1, host_wr = '0, host_rd = '0, uc_out_wr = '0, uc_in_rd = '0;
    logic uc_status_wr = '0, uc_port2_wr = '0, uc_en_flags = '0, uc_halt = '0, uc_stop = '0;
    logic uc_in_full_irq_en = '0, timer_ovf = '0, uc_timer_ack = '0, cfg_open_drain = '0;
    khm_byte_t host_addr = '0, host_wdata = '0, uc_out_data = '0, uc_status_user = '0;
    khm_byte_t uc_port2_data = '0, host_rdata, uc_in_data, uc_status, uc_port2, rd, b;
    logic host_rvalid, uc_in_full_irq, uc_timer_irq, alu_clk_en, timer_clk_en, osc_en, rv, seen;
    logic wake_call_irq, wake_next_instr, kbd_irq_out, aux_irq_out, gate_a20_o, gate_a20_oe_n;
    logic a20_pin;
    logic [3:0] kbd_mouse_pin_i, kbd_mouse_pin_o, kbd_mouse_pin_oe_n, pin_readback;
    logic [31:0] seed = 32'he;
    int n_mismatch = 0, tests_run = 0;

    // Short drive window keeps the release check quick
    khm_mailbox #(.DRIVE_CYC(DRV)) dut (.clock, .srst, .host_addr, .host_wr, .host_rd,
        .host_wdata, .host_rdata, .host_rvalid, .uc_out_wr, .uc_out_data, .uc_in_rd,
        .uc_in_data, .uc_status_wr, .uc_status_user, .uc_status, .uc_port2_wr,
        .uc_port2_data, .uc_port2, .uc_en_flags, .uc_halt, .uc_stop, .uc_in_full_irq_en,
        .timer_ovf, .uc_timer_ack, .uc_in_full_irq, .uc_timer_irq, .alu_clk_en, .timer_clk_en,
        .osc_en, .wake_call_irq, .wake_next_instr, .kbd_irq_out, .aux_irq_out, .cfg_open_drain,
        .gate_a20_o, .gate_a20_oe_n, .kbd_mouse_pin_i, .kbd_mouse_pin_o, .kbd_mouse_pin_oe_n,
        .pin_readback);
    khm_pins pins (.km_o(kbd_mouse_pin_o), .km_oe_n(kbd_mouse_pin_oe_n), .a20_o(gate_a20_o),
        .a20_oe_n(gate_a20_oe_n), .km_pin(kbd_mouse_pin_i), .a20_pin(a20_pin));

    // Compare and count
    task chk(input string n, input khm_byte_t s, input khm_byte_t e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic khm_byte_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Pins carry the inverted port bits, in pin index order
    function automatic logic [3:0] pins_exp(input khm_byte_t v);
        return ~{v[2], v[3], v[7], v[6]};
    endfunction
    // One-cycle strobe from a falling edge, then let flags and irqs settle
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task hw(input khm_byte_t a, input khm_byte_t d);
        host_addr = a;
        host_wdata = d;
        pulse(host_wr);
    endtask
    // Read valid stands only in the cycle after the taking edge; the data holds until the next port read
    task hr(input khm_byte_t a);
        host_addr = a;
        host_rd = 1'b1;
        @(negedge clock);
        rd = host_rdata;
        rv = host_rvalid;
        host_rd = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task p2(input khm_byte_t v);
        uc_port2_data = v;
        pulse(uc_port2_wr);
    endtask

    // Free-running clock
    initial begin
        forever #5 clock = ~clock;
    end
    // Main sequence
    initial begin
        repeat (8) @(negedge clock);
        chk("status rst", uc_status, 8'h00);
        chk("kbd irq rst", 8'(kbd_irq_out), 8'h00);
        chk("pins rst", 8'(kbd_mouse_pin_i), 8'h00);
        srst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            b = rnd();
            hw(i[0] ? 8'h64 : 8'h60, b);
            chk("in data", uc_in_data, b);
            chk("cd in full", uc_status & 8'h0a, {4'h0, i[0], 3'h2});
            pulse(uc_in_rd);
            chk("in full clr", uc_status & 8'h02, 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            b = rnd();
            uc_status_user = rnd();
            pulse(uc_status_wr);
            uc_out_data = b;
            pulse(uc_out_wr);
            hr(8'h64);
            chk("status", rd, (uc_status_user & 8'hf4) | 8'h09);
            hr(8'h60);
            chk("out data", rd, b);
            chk("rvalid", 8'(rv), 8'h01);
            chk("out full clr", uc_status & 8'h01, 8'h00);
        end
        hr(8'h61);
        chk("unmapped", 8'(rv), 8'h00);
        for (int i = 0; i < 8; i++) begin
            b = rnd();
            p2(b);
            repeat (4) @(negedge clock);
            chk("port copy", uc_port2, b);
            chk("kbd irq", 8'(kbd_irq_out), 8'(b[4]));
            chk("airq", 8'(aux_irq_out), 8'(b[5]));
            chk("pins", 8'(kbd_mouse_pin_i), 8'(pins_exp(b)));
            chk("readback", 8'(pin_readback), 8'(pins_exp(b)));
        end
        p2(8'h00);
        chk("a20 low", {6'h0, gate_a20_o, gate_a20_oe_n}, 8'h00);
        p2(8'h02);
        chk("a20 drive", {6'h0, gate_a20_o, gate_a20_oe_n}, 8'h02);
        repeat (DRV + 2) @(negedge clock);
        chk("a20 rel", {6'h0, a20_pin, gate_a20_oe_n}, 8'h03);
        cfg_open_drain = 1'b1;
        p2(8'h00);
        chk("od low", 8'(a20_pin), 8'h00);
        uc_port2_data = 8'h02;
        uc_port2_wr = 1'b1;
        for (int k = 0; k < 6; k++) begin
            @(negedge clock);
            uc_port2_wr = 1'b0;
            chk("od rel", 8'(gate_a20_oe_n), 8'(k > 0));
        end
        for (int i = 0; i < 2; i++) begin
            if (i == 0) pulse(uc_halt);
            else pulse(uc_stop);
            chk("asleep", {5'h0, timer_clk_en, alu_clk_en, osc_en}, i ? 8'h00 : 8'h05);
            uc_in_full_irq_en = (i == 0);
            host_addr = 8'h60;
            host_wdata = rnd();
            host_wr = 1'b1;
            seen = 1'b0;
            for (int k = 0; k < 4; k++) begin
                @(negedge clock);
                host_wr = 1'b0;
                seen |= i ? wake_next_instr : wake_call_irq;
            end
            chk("wake", 8'(seen), 8'h01);
            if (seen !== 1'b1) stop_test();
            chk("awake", {5'h0, timer_clk_en, alu_clk_en, osc_en}, 8'h07);
            chk("in full irq", 8'(uc_in_full_irq), 8'(i == 0));
            pulse(uc_in_rd);
        end
        pulse(timer_ovf);
        chk("tmr irq", 8'(uc_timer_irq), 8'h01);
        pulse(uc_timer_ack);
        chk("tmr ack", 8'(uc_timer_irq), 8'h00);
        pulse(uc_en_flags);
        p2(8'h30);
        chk("flag irqs", {6'h0, kbd_irq_out, aux_irq_out}, 8'h01);
        pulse(uc_out_wr);
        chk("kbd irq full", 8'(kbd_irq_out), 8'h01);
        hr(8'h60);
        chk("kbd irq clr", 8'(kbd_irq_out), 8'h00);
        hw(8'h60, rnd());
        chk("aux irq full", 8'(aux_irq_out), 8'h00);
        pulse(uc_out_wr);
        p2(8'h20);
        chk("kbd irq mask", 8'(kbd_irq_out), 8'h00);
        // Mid-run reset drops flag enabling and clears status and irqs
        srst = 1'b1;
        repeat (2) @(negedge clock);
        chk("irqs reset", {6'h0, kbd_irq_out, aux_irq_out}, 8'h00);
        chk("status reset", uc_status, 8'h00);
        chk("pins reset", 8'(kbd_mouse_pin_i), 8'h00);
        srst = 1'b0;
        p2(8'h10);
        chk("flags off", 8'(kbd_irq_out), 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire

// >>> verif/khm_pins.sv
// Pull-up model of the board wires behind the port pins
`timescale 1ns/1ps
`default_nettype none
module khm_pins (
    // Driven side
    input wire logic [3:0] km_o,
    input wire logic [3:0] km_oe_n,
    input wire logic a20_o,
    input wire logic a20_oe_n,
    // Wire levels
    output logic [3:0] km_pin,
    output logic a20_pin
);
    // A released line floats to the pull-up, so a stale low cannot pass
    assign km_pin = km_oe_n | km_o;
    assign a20_pin = a20_oe_n | a20_o;
endmodule
`default_nettype wire
